// File: tdc_cfg_pkg.sv
// Shared constants and types for the converter's configuration register bank.
// Assumes a 40 MHz reference clock and a serial host using clock phase 1, polarity 0.
package tdc_cfg_pkg;

	// Register file geometry
	localparam int NUM_REGS   = 7;
	localparam int REG_W      = 32;
	localparam int ID_W       = 8;
	localparam int CFG_W      = REG_W - ID_W;
	localparam int ADDR_W     = 3;
	localparam int RD_ENTRIES = 8;

	// Register addresses
	localparam logic [ADDR_W-1:0] REG_LEGACY_EXT = 3'h1;
	localparam logic [ADDR_W-1:0] ADDR_COMM_TEST = 3'h5;
	localparam logic [ADDR_W-1:0] REG_EXT        = 3'h6;
	localparam logic [ADDR_W-1:0] REG_MEAS_MODE  = 3'h0;
	localparam logic [ADDR_W-1:0] ADDR_LIMIT     = ADDR_W'(NUM_REGS);
	localparam logic [REG_W-1:0]  REG_RESET      = 32'h0000_0000;

	// Serial opcode layout: command nibble on top, register address at the bottom
	localparam int          OP_W      = 8;
	localparam int          OP_CMD_HI = 7;
	localparam int          OP_CMD_LO = 4;
	localparam logic [3:0]  OP_WRITE  = 4'h8;
	localparam logic [3:0]  OP_READ   = 4'hB;
	localparam logic [7:0]  OP_RESET  = 8'h50;

	// Frame bit counter landmarks
	localparam int                FRAME_BITS     = OP_W + REG_W;
	localparam int                CNT_W          = 6;
	localparam logic [CNT_W-1:0]  CNT_FIRST      = 6'h00;
	localparam logic [CNT_W-1:0]  CNT_OP_LAST    = CNT_W'(OP_W - 1);
	localparam logic [CNT_W-1:0]  CNT_READ_FIRST = CNT_W'(OP_W);
	localparam logic [CNT_W-1:0]  CNT_READ_END   = CNT_W'(OP_W + ID_W);
	localparam logic [CNT_W-1:0]  CNT_FRAME_LAST = CNT_W'(FRAME_BITS - 1);
	localparam logic [CNT_W-1:0]  CNT_FRAME_END  = CNT_W'(FRAME_BITS);

	// Configuration fields that steer the activity timer
	localparam int MODE2_BIT     = 11;
	localparam int EN_ANALOG_BIT = 31;

	// Timing of the measuring unit and the analog section
	localparam int         CAL_PERIODS_M1 = 2;
	localparam int         ACT_PERIODS_M2 = 4;
	localparam logic [2:0] CAL_LOAD       = 3'(CAL_PERIODS_M1 - 1);
	localparam logic [2:0] ACT_LOAD       = 3'(ACT_PERIODS_M2 - 1);
	localparam int         REF_CLK_KHZ    = 40000;
	localparam int         ANALOG_TIME_US = 250;
	localparam int         ANALOG_CYCLES  = (ANALOG_TIME_US * REF_CLK_KHZ) / 1000;

	typedef logic [REG_W-1:0]           word_t;
	typedef logic [ID_W-1:0]            byte_t;
	typedef word_t [NUM_REGS-1:0]       reg_file_t;
	typedef byte_t [RD_ENTRIES-1:0]     rd_table_t;

	// Completed serial command handed to the reference domain
	typedef struct packed {
		logic [OP_W-1:0] opcode;
		word_t           data;
	} link_word_s;

	// Extended controls: upper part of the extension register plus low byte of register 1
	typedef struct packed {
		logic [CFG_W-1:0] upper;
		byte_t            id1;
	} ext_cfg_s;

	typedef enum logic [1:0] {
		TMU_IDLE = 2'b00,
		TMU_MEAS = 2'b01,
		TMU_CAL  = 2'b10,
		TMU_FIX  = 2'b11
	} tmu_state_e;

endpackage : tdc_cfg_pkg

// File: spi_link.sv
// Serial port front end running on the host's serial clock.
// Assumes clock phase 1, polarity 0: sample on falling edge, launch on rising edge,
// and a serial clock that only toggles while the slave select is low.
`timescale 1ns/10ps
module spi_link (
	input  logic                   sclk,
	input  logic                   ssn_n,
	input  logic                   reset_pin_n,
	input  logic                   si,
	input  tdc_cfg_pkg::rd_table_t rd_bytes,
	output logic                   so,
	output logic                   so_oe,
	output tdc_cfg_pkg::link_word_s word,
	output logic                   done
);
	import tdc_cfg_pkg::*;

	typedef struct packed {
		logic [CNT_W-1:0]      cnt;
		logic [FRAME_BITS-1:0] sh;
		logic [OP_W-1:0]       op;
	} frame_s;

	typedef struct packed {
		link_word_s word;
		logic       done;
	} hold_s;

	typedef struct packed {
		logic obit;
		logic oe;
	} launch_s;

	frame_s  fr_q, fr_d;
	hold_s   hd_q, hd_d;
	launch_s ps_q, ps_d;

	// Shift on falling edges, catch the opcode and finished words
	always_comb
	begin
		fr_d = fr_q;
		hd_d = hd_q;
		ps_d.oe = (fr_q.op[OP_CMD_HI:OP_CMD_LO] == OP_READ) &&
			(fr_q.cnt >= CNT_READ_FIRST) && (fr_q.cnt < CNT_READ_END);
		ps_d.obit = ps_d.oe & rd_bytes[fr_q.op[ADDR_W-1:0]][~fr_q.cnt[2:0]]; // MSB first
		if (fr_q.cnt < CNT_FRAME_END)
		begin
			fr_d.sh = {fr_q.sh[FRAME_BITS-2:0], si};
			fr_d.cnt = fr_q.cnt + 1'b1;
		end
		if (fr_q.cnt == CNT_FIRST)
			hd_d.done = 1'b0; // New frame withdraws the previous hand-over
		if (fr_q.cnt == CNT_OP_LAST)
		begin
			fr_d.op = {fr_q.sh[OP_W-2:0], si};
			if ({fr_q.sh[OP_W-2:0], si} == OP_RESET)
			begin
				hd_d.word.opcode = OP_RESET;
				hd_d.word.data = REG_RESET;
				hd_d.done = 1'b1;
			end
		end
		if ((fr_q.cnt == CNT_FRAME_LAST) && (fr_q.op[OP_CMD_HI:OP_CMD_LO] == OP_WRITE))
		begin
			hd_d.word.opcode = fr_q.op;
			hd_d.word.data = {fr_q.sh[REG_W-2:0], si};
			hd_d.done = 1'b1;
		end
	end

	// Frame state clears whenever the slave select is high
	always_ff @(negedge sclk or posedge ssn_n)
	begin
		if (ssn_n)
			fr_q <= '0;
		else
			fr_q <= fr_d;
	end

	// Hand-over word survives the frame end so the reference side can fetch it
	always_ff @(negedge sclk or negedge reset_pin_n)
	begin
		if (!reset_pin_n)
			hd_q <= '0;
		else
			hd_q <= hd_d;
	end

	// Read data launched on rising edges
	always_ff @(posedge sclk or posedge ssn_n)
	begin
		if (ssn_n)
			ps_q <= '0;
		else
			ps_q <= ps_d;
	end

	assign so = ps_q.obit;
	assign so_oe = ps_q.oe;
	assign word = hd_q.word;
	assign done = hd_q.done;

	so_quiet_a: assert property (@(posedge sclk) disable iff (ssn_n)
		(fr_q.cnt < CNT_READ_FIRST) |=> !so_oe)
		else $error("Serial output driven during opcode phase");

	// No sclk edge follows the last data bit, so the hand-over is judged at its capture edge
	word_capture_a: assert property (@(negedge sclk) disable iff (ssn_n)
		((fr_q.cnt == CNT_FRAME_LAST) && (fr_q.op[OP_CMD_HI:OP_CMD_LO] == OP_WRITE))
		|-> (hd_d.done && (hd_d.word.data[0] == si) && (hd_d.word.opcode == fr_q.op)))
		else $error("Write frame not handed over");

endmodule : spi_link

// File: tmu_timer.sv
// Activity windows of the time measuring unit and the analog section.
// Assumes one-cycle start and stop strobes on the reference clock.
`timescale 1ns/10ps
module tmu_timer #(
	parameter int ANALOG_CYCLES_P = tdc_cfg_pkg::ANALOG_CYCLES
) (
	input  logic ref_clk,
	input  logic clear_b,
	input  logic mode2,
	input  logic en_analog,
	input  logic meas_start,
	input  logic meas_stop,
	output logic tmu_active,
	output logic analog_en
);
	import tdc_cfg_pkg::*;

	localparam int AW = $clog2(ANALOG_CYCLES_P + 1);
	localparam logic [AW-1:0] ANA_LOAD = AW'(ANALOG_CYCLES_P - 1);

	typedef struct packed {
		tmu_state_e st;
		logic [2:0] cnt;
		logic       tmu;
		logic [AW-1:0] acnt;
		logic       ana;
		logic       ana_cd;
	} tmr_s;

	tmr_s s_q, s_d;

	// Measuring unit sequence and analog window
	always_comb
	begin
		s_d = s_q;
		case (s_q.st)
			TMU_IDLE:
				if (meas_start)
				begin
					s_d.tmu = 1'b1;
					s_d.st = mode2 ? TMU_FIX : TMU_MEAS;
					s_d.cnt = ACT_LOAD;
				end
			TMU_MEAS:
				if (meas_stop)
				begin
					s_d.st = TMU_CAL;
					s_d.cnt = CAL_LOAD;
				end
			TMU_CAL, TMU_FIX:
				if (s_q.cnt == 3'h0)
				begin
					s_d.st = TMU_IDLE;
					s_d.tmu = 1'b0;
				end
				else
					s_d.cnt = s_q.cnt - 1'b1;
			default:
			begin
				s_d.st = TMU_IDLE;
				s_d.tmu = 1'b0;
			end
		endcase
		// Analog on from start, off a fixed time after stop
		if (!s_q.ana && meas_start && en_analog)
		begin
			s_d.ana = 1'b1;
			s_d.ana_cd = 1'b0;
		end
		else if (s_q.ana && !s_q.ana_cd && meas_stop)
		begin
			s_d.ana_cd = 1'b1;
			s_d.acnt = ANA_LOAD;
		end
		else if (s_q.ana_cd)
		begin
			if (s_q.acnt == '0)
			begin
				s_d.ana = 1'b0;
				s_d.ana_cd = 1'b0;
			end
			else
				s_d.acnt = s_q.acnt - 1'b1;
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (!clear_b)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign tmu_active = s_q.tmu;
	assign analog_en = s_q.ana;

	sequence cal_tail;
		tmu_active [*2] ##1 !tmu_active;
	endsequence

	sequence fix_window;
		tmu_active [*4] ##1 !tmu_active;
	endsequence

	tmu_cal_a: assert property (@(posedge ref_clk) disable iff (!clear_b)
		((s_q.st == TMU_MEAS) && meas_stop) |=> cal_tail)
		else $error("Calibration tail not two periods");

	tmu_mode2_a: assert property (@(posedge ref_clk) disable iff (!clear_b)
		((s_q.st == TMU_IDLE) && meas_start && mode2) |=> fix_window)
		else $error("Mode 2 window not four periods");

	analog_on_a: assert property (@(posedge ref_clk) disable iff (!clear_b)
		(!analog_en && meas_start && en_analog) |=> analog_en)
		else $error("Analog section not enabled at start");

	analog_off_a: assert property (@(posedge ref_clk) disable iff (!clear_b)
		(!analog_en && !(meas_start && en_analog)) |=> !analog_en)
		else $error("Analog section enabled without start");

	analog_end_a: assert property (@(posedge ref_clk) disable iff (!clear_b)
		(s_q.ana_cd && (s_q.acnt == '0)) |=> !analog_en)
		else $error("Analog section overstays its window");

endmodule : tmu_timer

// File: tdc_config_bank.sv
// Configuration register bank of a two-channel time-to-digital converter.
// Assumes a serial host on sclk/ssn_n/si/so and measurement strobes on ref_clk.
`timescale 1ns/10ps
// Function
// - Seven 32-bit configuration registers set the operating mode.
// - Upper 24 bits of each register are write-only; only register 1's top byte reads back, at address 5.
// - Lowest 8 bits of each register are writable; all but register 5's are readable, e.g. as ID.
// - Reading address 5 returns top byte last written to register 1.
// - Extended functions come only from register 6 and register 1 low byte.
// - Mode 1: measuring unit on start to stop, plus two calibration periods.
// - Analog section on for 250 us plus time-of-flight, otherwise off.
// - Serial port uses clock phase one, polarity zero, idle low.
module tdc_config_bank #(
	parameter int ANALOG_CYCLES_P = tdc_cfg_pkg::ANALOG_CYCLES
) (
	input  logic                                   ref_clk,
	input  logic                                   rst_b,
	input  logic                                   sclk,
	input  logic                                   ssn_n,
	input  logic                                   si,
	output logic                                   so,
	output logic                                   so_oe,
	input  logic                                   reset_pin_n,
	input  logic                                   meas_start,
	input  logic                                   meas_stop,
	output logic [tdc_cfg_pkg::NUM_REGS-2:0][tdc_cfg_pkg::CFG_W-1:0] legacy_cfg,
	output tdc_cfg_pkg::ext_cfg_s                  ext_cfg,
	output logic                                   tmu_active,
	output logic                                   analog_en
);
	import tdc_cfg_pkg::*;

	// Reference-domain state outside the timer
	typedef struct packed {
		logic      rpin_s1;
		logic      rpin_s2;
		logic      done_s1;
		logic      done_s2;
		logic      done_s3;
		logic      run;
		reg_file_t regs;
		rd_table_t rd;
	} top_s;

	top_s       q, d;
	link_word_s link_word;
	logic       link_done;
	logic       evt;
	logic       is_write;
	logic       is_bad_write;
	logic       is_rst_cmd;
	logic [ADDR_W-1:0] wr_addr;
	word_t      wr_data;
	byte_t      wr_id;
	byte_t      wr_top;

	// Readback table: only the low byte of each register but register 5, plus the test mirror at address 5
	function automatic rd_table_t read_map(input reg_file_t regs);
		rd_table_t t;
		t = '0;
		for (int i = 0; i < NUM_REGS; i++)
			t[i] = regs[i][ID_W-1:0];
		t[ADDR_COMM_TEST] = regs[REG_LEGACY_EXT][REG_W-1 -: ID_W];
		return t;
	endfunction : read_map

	// Serial clock domain front end
	spi_link u_link (
		.sclk        (sclk),
		.ssn_n       (ssn_n),
		.reset_pin_n (reset_pin_n),
		.si          (si),
		.rd_bytes    (q.rd),
		.so          (so),
		.so_oe       (so_oe),
		.word        (link_word),
		.done        (link_done)
	);

	// Activity windows, cleared with the rest of the device
	tmu_timer #(
		.ANALOG_CYCLES_P (ANALOG_CYCLES_P)
	) u_timer (
		.ref_clk    (ref_clk),
		.clear_b    (q.run),
		.mode2      (q.regs[REG_MEAS_MODE][MODE2_BIT]),
		.en_analog  (q.regs[REG_EXT][EN_ANALOG_BIT]),
		.meas_start (meas_start),
		.meas_stop  (meas_stop),
		.tmu_active (tmu_active),
		.analog_en  (analog_en)
	);

	// Decode of a freshly arrived serial command
	assign evt = q.done_s2 && !q.done_s3;
	assign wr_addr = link_word.opcode[ADDR_W-1:0];
	assign wr_data = link_word.data;
	assign wr_id = link_word.data[ID_W-1:0];
	assign wr_top = link_word.data[REG_W-1 -: ID_W];
	assign is_write = evt && (link_word.opcode[OP_CMD_HI:OP_CMD_LO] == OP_WRITE) &&
		(wr_addr < ADDR_LIMIT);
	assign is_bad_write = evt && (link_word.opcode[OP_CMD_HI:OP_CMD_LO] == OP_WRITE) &&
		(wr_addr >= ADDR_LIMIT);
	assign is_rst_cmd = evt && (link_word.opcode == OP_RESET);

	// Next state: synchronisers, register writes, resets, readback table
	always_comb
	begin
		d = q;
		d.rpin_s1 = reset_pin_n;
		d.rpin_s2 = q.rpin_s1;
		d.done_s1 = link_done;
		d.done_s2 = q.done_s1;
		d.done_s3 = q.done_s2;
		d.run = q.rpin_s2 && !is_rst_cmd;
		if (!q.rpin_s2 || is_rst_cmd)
			d.regs = {NUM_REGS{REG_RESET}};
		else if (is_write)
			d.regs[wr_addr] = wr_data;
		d.rd = read_map(q.regs);
	end

	always_ff @(posedge ref_clk)
	begin
		if (!rst_b)
			q <= '0;
		else
			q <= d;
	end

	// Legacy fields and extended controls straight from the register flops
	always_comb
	begin
		for (int i = 0; i < NUM_REGS - 1; i++)
			legacy_cfg[i] = q.regs[i][REG_W-1:ID_W];
		ext_cfg.upper = q.regs[REG_EXT][REG_W-1:ID_W];
		ext_cfg.id1 = q.regs[REG_LEGACY_EXT][ID_W-1:0];
	end

	sequence table_settle;
		##1 1'b1 ##1 1'b1;
	endsequence

	write_update_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(is_write && q.rpin_s2) |=> (q.regs[$past(wr_addr)] == $past(wr_data)))
		else $error("Register write not stored");

	unmapped_write_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(is_bad_write && q.rpin_s2) |=> $stable(q.regs))
		else $error("Write to unmapped address changed a register");

	upper_hidden_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(is_write && q.rpin_s2 && (wr_addr != REG_LEGACY_EXT) &&
		(wr_id == q.regs[wr_addr][ID_W-1:0])) |=> ##1 $stable(q.rd))
		else $error("Upper bits leaked into readback");

	id_read_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(is_write && q.rpin_s2 && (wr_addr != ADDR_COMM_TEST)) |-> table_settle ##0
		(q.rd[$past(wr_addr, 2)] == $past(wr_id, 2)))
		else $error("Identifier byte not readable");

	comm_test_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(is_write && q.rpin_s2 && (wr_addr == REG_LEGACY_EXT)) |-> table_settle ##0
		(q.rd[ADDR_COMM_TEST] == $past(wr_top, 2)))
		else $error("Address 5 does not mirror register 1 top byte");

	ext_map_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(is_write && q.rpin_s2 && (wr_addr != REG_EXT) && (wr_addr != REG_LEGACY_EXT))
		|=> $stable(ext_cfg))
		else $error("Extended controls moved by a legacy register");

	pin_reset_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		!q.rpin_s2 |=> ((q.regs == {NUM_REGS{REG_RESET}}) && !q.run))
		else $error("Pin reset did not clear the bank");

	cmd_reset_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
		is_rst_cmd |=> ((q.regs == {NUM_REGS{REG_RESET}}) && !q.run))
		else $error("Reset command did not clear the bank");

endmodule : tdc_config_bank

// File: spi_host_model.sv
// Host controller model: serial master using clock phase 1, polarity 0.
// Assumes the bench calls xfer from one process at a time.
`timescale 1ns/10ps
module spi_host_model (
	output logic      sclk,
	output logic      ssn_n,
	output logic      si,
	input  wire logic so
);
	// Idle bus: clock low, slave not selected; a select edge at start clears the port
	initial
	begin
		sclk  = 1'b0;
		ssn_n = 1'b0;
		si    = 1'b0;
		#1;
		ssn_n = 1'b1;
	end

	// One frame of n bits taken MSB first from bits; read byte from bits 9..16
	task automatic xfer(input logic [39:0] bits, input int n, output logic [7:0] rd);
		rd = 8'h00;
		ssn_n <= 1'b0;
		#80;
		for (int i = 0; i < n; i++)
		begin
			sclk <= 1'b1;
			si   <= bits[39-i];
			#80;
			sclk <= 1'b0;
			if (i >= 8 && i < 16)
				rd = {rd[6:0], so};
			#80;
		end
		ssn_n <= 1'b1;
		// Released line must not keep showing the last bit
		si    <= ~bits[40-n];
		#320;
	endtask : xfer
endmodule : spi_host_model

// File: tdc_config_bank_tb_top.sv
// Self-checking bench for the configuration register bank.
// Assumes the serial host model and a shortened analog window.
`timescale 1ns/10ps
module tdc_config_bank_tb_top;
	import tdc_cfg_pkg::*;
	localparam int AN = 20;

	logic                                 ref_clk;
	logic                                 rst_b;
	logic                                 sclk;
	logic                                 ssn_n;
	logic                                 si;
	logic                                 so;
	logic                                 so_oe;
	logic                                 reset_pin_n;
	logic                                 meas_start;
	logic                                 meas_stop;
	logic [NUM_REGS-2:0][CFG_W-1:0]       legacy_cfg;
	ext_cfg_s                             ext_cfg;
	logic                                 tmu_active;
	logic                                 analog_en;
	word_t                                exp_q [NUM_REGS];
	int                                   err_count = 0;
	int                                   checks_done = 0;

	tdc_config_bank #(.ANALOG_CYCLES_P(AN)) uut (
		.ref_clk(ref_clk), .rst_b(rst_b), .sclk(sclk), .ssn_n(ssn_n), .si(si), .so(so),
		.so_oe(so_oe), .reset_pin_n(reset_pin_n), .meas_start(meas_start),
		.meas_stop(meas_stop), .legacy_cfg(legacy_cfg), .ext_cfg(ext_cfg),
		.tmu_active(tmu_active), .analog_en(analog_en)
	);

	spi_host_model host (.sclk(sclk), .ssn_n(ssn_n), .si(si), .so(so));

	// Reference clock, 25 ns period
	initial
		ref_clk = 1'b0;
	always #12.5 ref_clk = ~ref_clk;

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic report_and_stop();
		$display("checks %0d, mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : report_and_stop

	task automatic wr(input logic [2:0] a, input word_t d);
		logic [7:0] b;
		host.xfer({5'b10000, a, d}, 40, b);
	endtask : wr

	task automatic rd(input logic [2:0] a, output logic [7:0] b);
		host.xfer({5'b10110, a, 32'h0}, 16, b);
	endtask : rd

	// Everything cleared after the bench reset
	task automatic t_reset_values();
		logic [7:0] b;
		for (int i = 0; i < NUM_REGS - 1; i++)
			chk("legacy_cfg", 32'(legacy_cfg[i]), 32'h0);
		chk("ext_cfg", ext_cfg, 32'h0);
		chk("tmu_active", 32'(tmu_active), 32'h0);
		chk("analog_en", 32'(analog_en), 32'h0);
		rd(3'h0, b);
		chk("id0", 32'(b), 32'h0);
	endtask : t_reset_values

	// All registers written, bad address and short frame refused, bytes read back
	task automatic t_regs();
		logic [7:0] b;
		word_t      e;
		for (int i = 0; i < NUM_REGS; i++)
		begin
			exp_q[i] = {8'h31 + 8'(i), 8'hC6, 8'h50 + 8'(i), 8'hA0 + 8'(i)};
			wr(3'(i), exp_q[i]);
		end
		wr(3'h7, 32'hFFFF_FFFF);
		host.xfer({8'h81, 32'h0}, 20, b);
		for (int i = 0; i < NUM_REGS - 1; i++)
			chk("legacy_cfg", 32'(legacy_cfg[i]), 32'(exp_q[i][31:8]));
		chk("ext_cfg", ext_cfg, {exp_q[6][31:8], exp_q[1][7:0]});
		for (int i = 0; i < RD_ENTRIES; i++)
		begin
			rd(3'(i), b);
			e = (i == 5) ? 32'(exp_q[1][31:24]) : (i == 7) ? 32'h0 : 32'(exp_q[i][7:0]);
			chk("read byte", 32'(b), e);
		end
		// Output enable must stand while the read byte is shifted out
		fork
			rd(3'h2, b);
			begin
				repeat (9) @(negedge sclk);
				chk("so_oe read", 32'(so_oe), 32'h1);
			end
		join
		chk("read byte", 32'(b), 32'(exp_q[2][7:0]));
		chk("so_oe idle", 32'(so_oe), 32'h0);
	endtask : t_regs

	// One measurement: start, stop d cycles later, count active cycles
	task automatic meas(input int d, output int nt, output int na);
		nt = 0;
		na = 0;
		@(posedge ref_clk);
		fork
			begin
				meas_start <= 1'b1;
				@(posedge ref_clk);
				meas_start <= 1'b0;
				repeat (d - 1) @(posedge ref_clk);
				meas_stop <= 1'b1;
				@(posedge ref_clk);
				meas_stop <= 1'b0;
			end
			repeat (60)
			begin
				@(posedge ref_clk);
				#1;
				if (tmu_active === 1'b1)
					nt++;
				if (analog_en === 1'b1)
					na++;
			end
		join
	endtask : meas

	task automatic t_meas();
		int nt;
		int na;
		wr(REG_EXT, 32'h8000_0000);
		wr(3'h0, 32'h0);
		meas(5, nt, na);
		chk("mode1 active", 32'(nt), 32'(5 + CAL_PERIODS_M1));
		chk("analog window", 32'(na), 32'(5 + AN));
		wr(REG_EXT, 32'h0);
		wr(3'h0, 32'h0000_0800);
		meas(5, nt, na);
		chk("mode2 active", 32'(nt), 32'(ACT_PERIODS_M2));
		chk("analog off", 32'(na), 32'h0);
	endtask : t_meas

	// Serial reset command, then reset pin
	task automatic t_resets();
		logic [7:0] b;
		host.xfer({OP_RESET, 32'h0}, 8, b);
		chk("legacy_cfg", 32'(legacy_cfg[0]), 32'h0);
		chk("ext_cfg", ext_cfg, 32'h0);
		wr(3'h1, 32'hA5A5_A55A);
		chk("legacy_cfg", 32'(legacy_cfg[1]), 32'h00A5_A5A5);
		@(posedge ref_clk);
		reset_pin_n <= 1'b0;
		repeat (5) @(posedge ref_clk);
		reset_pin_n <= 1'b1;
		repeat (10) @(posedge ref_clk);
		chk("legacy_cfg", 32'(legacy_cfg[1]), 32'h0);
		rd(3'h1, b);
		chk("id1", 32'(b), 32'h0);
	endtask : t_resets

	// Main sequence
	initial
	begin
		rst_b       = 1'b0;
		reset_pin_n = 1'b1;
		meas_start  = 1'b0;
		meas_stop   = 1'b0;
		// Power-up reset through the pin, released with the bench reset
		@(posedge ref_clk);
		reset_pin_n <= 1'b0;
		repeat (4) @(posedge ref_clk);
		rst_b <= 1'b1;
		reset_pin_n <= 1'b1;
		repeat (8) @(posedge ref_clk);
		t_reset_values();
		t_regs();
		t_meas();
		t_resets();
		report_and_stop();
	end

	// Watchdog against a hung frame or wait
	initial
	begin
		#300000;
		err_count++;
		report_and_stop();
	end
endmodule : tdc_config_bank_tb_top
